// ---- rtl/plc_pkg.sv ----
package plc_pkg;
    localparam int CLK_MHZ         = 250;
    localparam int SAMPLE_US       = 1000;
    localparam int TICK_CYCLES     = SAMPLE_US * CLK_MHZ;
    localparam int FRAC            = 8;
    localparam int DIV_W           = 48;
    localparam int KP_DIV          = 10;
    localparam int PCT_DIV         = 1000;
    localparam int TI_US_PER_CODE  = 10000;
    localparam int TD_US_PER_CODE  = 10000;
    localparam int TF_US_PER_CODE  = 100000;
    localparam int D_SCALE         = TD_US_PER_CODE / SAMPLE_US;

    localparam logic [7:0] OFF_CTRL  = 8'h00;
    localparam logic [7:0] OFF_KP    = 8'h04;
    localparam logic [7:0] OFF_TI    = 8'h08;
    localparam logic [7:0] OFF_TD    = 8'h0C;
    localparam logic [7:0] OFF_ILIM  = 8'h10;
    localparam logic [7:0] OFF_OLIM  = 8'h14;
    localparam logic [7:0] OFF_FMAX  = 8'h18;
    localparam logic [7:0] OFF_TF    = 8'h1C;
    localparam logic [7:0] OFF_SETP  = 8'h20;
    localparam logic [7:0] OFF_FBCOM = 8'h24;
    localparam logic [7:0] OFF_STAT  = 8'h28;
    localparam logic [7:0] OFF_INTEG = 8'h2C;
    localparam logic [7:0] OFF_ERR   = 8'h30;

    localparam int CTRL_EN_BIT   = 0;
    localparam int CTRL_PAR_BIT  = 1;
    localparam int CTRL_FB_LSB   = 4;
    localparam int STAT_BUSY_BIT = 16;

    localparam logic [3:0] FB_NONE    = 4'h0;
    localparam logic [3:0] FB_POS_AI  = 4'h4;
    localparam logic [3:0] FB_POS_PG  = 4'h5;
    localparam logic [3:0] FB_NEG_COM = 4'h7;
    localparam logic [3:0] FB_POS_COM = 4'h8;

    typedef logic signed [63:0] plc_wide_t;

    typedef struct packed {
        logic        en;
        logic        par;
        logic [3:0]  fbsel;
        logic [15:0] kp;
        logic [15:0] ti;
        logic [15:0] td;
        logic [15:0] ilim;
        logic [15:0] olim;
        logic [15:0] fmax;
        logic [15:0] tf;
        logic [15:0] setp;
        logic [15:0] fbcom;
    } plc_cfg_t;

    localparam plc_cfg_t CFG_RST = '{en: 1'b0, par: 1'b0, fbsel: 4'h0, kp: 16'h000A, ti: 16'h0064,
                                     td: 16'h0000, ilim: 16'h03E8, olim: 16'h03E8, fmax: 16'h1770,
                                     tf: 16'h0000, setp: 16'h0000, fbcom: 16'h0000};

    typedef enum logic [2:0] {ST_IDLE, ST_INT_DIV, ST_SUM, ST_FLT_DIV, ST_OUT} plc_state_t;
endpackage

// ---- rtl/plc_pid_loop_controller.sv ----
// The register addresses and the APB register port were decided locally.
`timescale 1ns/10ps
// Summary of operation
// - Proportional gain, ten codes equal unity
// - Zero I and D leaves proportional only
// - Integral step divided by integral time
// - Integral time zero clears integral term
// - Integrator accumulates until error is zero
// - Derivative is error change times time
// - Unchanged error gives zero derivative
// - Integral clamped to max frequency percentage
// - Error formed from set point, feedback
// - Feedback polarity chooses error sign
// - Output limited to max frequency percentage
// - Mode bit picks serial or parallel
// - First-order low-pass on controller output
module plc_pid_loop_controller
#(
    parameter int TICK_CYCLES = plc_pkg::TICK_CYCLES // Clock cycles per control sample
)
(
    input  wire logic        sys_clk,     // System clock
    input  wire logic        nrst,        // Asynchronous reset, active low
    input  wire logic        psel,        // APB select
    input  wire logic        penable,     // APB enable
    input  wire logic        pwrite,      // APB direction
    input  wire logic [7:0]  paddr,       // APB byte address
    input  wire logic [31:0] pwdata,      // APB write data
    output logic      [31:0] prdata,      // APB read data
    output logic             pready,      // APB ready
    output logic             pslverr,     // APB error, unmapped address
    input  wire logic [15:0] fb_value_in, // Feedback sensor value pins
    output logic      [15:0] cmd_freq,    // Frequency command
    output logic             cmd_update   // Pulse on each new command
);
    localparam int TW = $clog2(TICK_CYCLES + 1);
    localparam plc_pkg::plc_wide_t U_SAT = 64'h0000_0000_7FFF_FFFF;

    function automatic plc_pkg::plc_wide_t plc_sat(input plc_pkg::plc_wide_t v,
                                                   input plc_pkg::plc_wide_t lo,
                                                   input plc_pkg::plc_wide_t hi);
        return (v > hi) ? hi : ((v < lo) ? lo : v);
    endfunction
    function automatic plc_pkg::plc_wide_t plc_abs(input plc_pkg::plc_wide_t v);
        return (v < 0) ? -v : v;
    endfunction
    logic                 rst_meta_ff;
    logic                 rst_n_ff;
    logic [15:0]          fb_meta_ff;
    logic [15:0]          fb_sync_ff;
    logic [TW-1:0]        tick_cnt_ff;
    logic                 tick_ff;
    logic                 pready_ff;
    logic                 pslverr_ff;
    logic [31:0]          prdata_ff;
    plc_pkg::plc_cfg_t    cfg_ff;
    plc_pkg::plc_state_t  st_ff;
    plc_pkg::plc_wide_t   err_ff;
    plc_pkg::plc_wide_t   d_ff;
    plc_pkg::plc_wide_t   integ_ff;
    plc_pkg::plc_wide_t   filt_ff;
    logic [15:0]          cmd_freq_ff;
    logic                 cmd_update_ff;
    logic                 div_busy_ff;
    logic                 div_done_ff;
    logic                 div_neg_ff;
    logic [5:0]           div_cnt_ff;
    logic [47:0]          div_rem_ff;
    logic [47:0]          div_quo_ff;
    logic [31:0]          div_den_ff;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n_ff);
    // Reset release is synchronised so every flop reset by rst_n_ff leaves reset on the same edge
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_meta_ff <= 1'b0;
            rst_n_ff    <= 1'b0;
        end
        else
        begin
            rst_meta_ff <= 1'b1;
            rst_n_ff    <= rst_meta_ff;
        end
    end

    wire logic tick_wrap = (tick_cnt_ff == TW'(TICK_CYCLES - 1));
    // Word-wide pin sync: assumes the sensor value moves slowly against the sample rate
    always_ff @(posedge sys_clk or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            fb_meta_ff  <= 16'h0000;
            fb_sync_ff  <= 16'h0000;
            tick_cnt_ff <= '0;
            tick_ff     <= 1'b0;
        end
        else
        begin
            fb_meta_ff  <= fb_value_in;
            fb_sync_ff  <= fb_meta_ff;
            tick_cnt_ff <= tick_wrap ? '0 : tick_cnt_ff + 1'b1;
            tick_ff     <= tick_wrap;
        end
    end
    property p_tick_period;
        tick_ff |-> $past(tick_cnt_ff) == TW'(TICK_CYCLES - 1);
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("sample tick off period");
    // APB slave: one wait state, write lands at the edge that completes the access
    wire logic acc_first = psel & penable & ~pready_ff;
    wire logic wr_en     = psel & penable & pready_ff & pwrite;
    wire logic core_busy = (st_ff != plc_pkg::ST_IDLE);
    wire logic mapped    = (paddr[1:0] == 2'b00) && (paddr <= plc_pkg::OFF_ERR);
    wire logic [31:0] rd_data =
        (paddr == plc_pkg::OFF_CTRL)  ? {24'h00_0000, cfg_ff.fbsel, 2'h0, cfg_ff.par, cfg_ff.en} :
        (paddr == plc_pkg::OFF_KP)    ? {16'h0000, cfg_ff.kp}    :
        (paddr == plc_pkg::OFF_TI)    ? {16'h0000, cfg_ff.ti}    :
        (paddr == plc_pkg::OFF_TD)    ? {16'h0000, cfg_ff.td}    :
        (paddr == plc_pkg::OFF_ILIM)  ? {16'h0000, cfg_ff.ilim}  :
        (paddr == plc_pkg::OFF_OLIM)  ? {16'h0000, cfg_ff.olim}  :
        (paddr == plc_pkg::OFF_FMAX)  ? {16'h0000, cfg_ff.fmax}  :
        (paddr == plc_pkg::OFF_TF)    ? {16'h0000, cfg_ff.tf}    :
        (paddr == plc_pkg::OFF_SETP)  ? {16'h0000, cfg_ff.setp}  :
        (paddr == plc_pkg::OFF_FBCOM) ? {16'h0000, cfg_ff.fbcom} :
        (paddr == plc_pkg::OFF_STAT)  ? {15'h0000, core_busy, cmd_freq_ff} :
        (paddr == plc_pkg::OFF_INTEG) ? integ_ff[plc_pkg::FRAC+31:plc_pkg::FRAC] :
        (paddr == plc_pkg::OFF_ERR)   ? err_ff[31:0] : 32'h0000_0000;

    always_ff @(posedge sys_clk or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end
        else
        begin
            pready_ff  <= acc_first;
            pslverr_ff <= acc_first & ~mapped;
            prdata_ff  <= acc_first ? rd_data : 32'h0000_0000;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
            cfg_ff <= plc_pkg::CFG_RST;
        else if (wr_en)
        begin
            case (paddr)
                plc_pkg::OFF_CTRL:
                begin
                    cfg_ff.en    <= pwdata[plc_pkg::CTRL_EN_BIT];
                    cfg_ff.par   <= pwdata[plc_pkg::CTRL_PAR_BIT];
                    cfg_ff.fbsel <= pwdata[plc_pkg::CTRL_FB_LSB +: 4];
                end
                plc_pkg::OFF_KP:    cfg_ff.kp    <= pwdata[15:0];
                plc_pkg::OFF_TI:    cfg_ff.ti    <= pwdata[15:0];
                plc_pkg::OFF_TD:    cfg_ff.td    <= pwdata[15:0];
                plc_pkg::OFF_ILIM:  cfg_ff.ilim  <= pwdata[15:0];
                plc_pkg::OFF_OLIM:  cfg_ff.olim  <= pwdata[15:0];
                plc_pkg::OFF_FMAX:  cfg_ff.fmax  <= pwdata[15:0];
                plc_pkg::OFF_TF:    cfg_ff.tf    <= pwdata[15:0];
                plc_pkg::OFF_SETP:  cfg_ff.setp  <= pwdata[15:0];
                plc_pkg::OFF_FBCOM: cfg_ff.fbcom <= pwdata[15:0];
                default:            cfg_ff       <= cfg_ff;
            endcase
        end
    end

    // Error and output limit in whole units; the terms, integral and filter in FRAC fractional bits
    wire logic is_com = (cfg_ff.fbsel == plc_pkg::FB_NEG_COM) || (cfg_ff.fbsel == plc_pkg::FB_POS_COM);
    wire logic is_pos = (cfg_ff.fbsel == plc_pkg::FB_POS_AI) || (cfg_ff.fbsel == plc_pkg::FB_POS_PG) ||
                        (cfg_ff.fbsel == plc_pkg::FB_POS_COM);
    wire plc_pkg::plc_wide_t sp_w  = plc_pkg::plc_wide_t'($signed(cfg_ff.setp));
    wire plc_pkg::plc_wide_t fb_w  = plc_pkg::plc_wide_t'($signed(is_com ? cfg_ff.fbcom : fb_sync_ff));
    wire plc_pkg::plc_wide_t err_w = (cfg_ff.fbsel == plc_pkg::FB_NONE) ? '0 :
                                     is_pos ? fb_w - sp_w : sp_w - fb_w;
    wire plc_pkg::plc_wide_t kp_w  = plc_pkg::plc_wide_t'(cfg_ff.kp);
    wire plc_pkg::plc_wide_t e8_w  = err_ff <<< plc_pkg::FRAC;
    wire plc_pkg::plc_wide_t d_w   = ((err_w - err_ff) * plc_pkg::plc_wide_t'(cfg_ff.td)
                                     * plc_pkg::D_SCALE) <<< plc_pkg::FRAC;
    wire plc_pkg::plc_wide_t p_w   = (e8_w * kp_w) / plc_pkg::KP_DIV;
    wire plc_pkg::plc_wide_t ser_w = ((e8_w + integ_ff + d_ff) * kp_w) / plc_pkg::KP_DIV;
    wire plc_pkg::plc_wide_t u_w   = plc_sat(cfg_ff.par ? p_w + integ_ff + d_ff : ser_w,
                                             -U_SAT, U_SAT);
    wire plc_pkg::plc_wide_t ilim_w = ((plc_pkg::plc_wide_t'(cfg_ff.fmax) * plc_pkg::plc_wide_t'(cfg_ff.ilim))
                                      / plc_pkg::PCT_DIV) <<< plc_pkg::FRAC;
    wire plc_pkg::plc_wide_t olim_w = (plc_pkg::plc_wide_t'(cfg_ff.fmax) * plc_pkg::plc_wide_t'(cfg_ff.olim))
                                      / plc_pkg::PCT_DIV;
    wire plc_pkg::plc_wide_t qs_w   = div_neg_ff ? -plc_pkg::plc_wide_t'(div_quo_ff)
                                                 : plc_pkg::plc_wide_t'(div_quo_ff);
    wire plc_pkg::plc_wide_t fdif_w = u_w - filt_ff;
    wire logic run_tick = tick_ff & cfg_ff.en & ~core_busy;
    wire logic int_go   = run_tick && (cfg_ff.ti != 16'h0000) && (err_w != 0);
    wire logic flt_go   = (st_ff == plc_pkg::ST_SUM) && (cfg_ff.tf != 16'h0000);
    wire logic div_go   = int_go | flt_go;

    // One shared divider serves the integral step and the filter step, trading latency for area
    wire logic [47:0] div_num_in = int_go ?
        48'((plc_abs(err_w) <<< plc_pkg::FRAC) * plc_pkg::SAMPLE_US) :
        48'(plc_abs(fdif_w) * plc_pkg::SAMPLE_US);
    wire logic [31:0] div_den_in = int_go ? 32'(cfg_ff.ti * plc_pkg::TI_US_PER_CODE) :
        32'(cfg_ff.tf * plc_pkg::TF_US_PER_CODE + plc_pkg::SAMPLE_US);
    wire logic        div_neg_in = int_go ? (err_w < 0) : (fdif_w < 0);
    wire logic [48:0] rem_sh     = {div_rem_ff, div_quo_ff[47]};
    wire logic [48:0] den_x      = {17'h0_0000, div_den_ff};
    wire logic        rem_ge     = (rem_sh >= den_x);
    wire logic [48:0] rem_dif    = rem_sh - den_x;
    wire logic [47:0] nxt_rem    = rem_ge ? rem_dif[47:0] : rem_sh[47:0];

    always_ff @(posedge sys_clk or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            div_busy_ff <= 1'b0;
            div_done_ff <= 1'b0;
            div_neg_ff  <= 1'b0;
            div_cnt_ff  <= 6'h00;
            div_rem_ff  <= 48'h0000_0000_0000;
            div_quo_ff  <= 48'h0000_0000_0000;
            div_den_ff  <= 32'h0000_0000;
        end
        else if (div_go)
        begin
            div_busy_ff <= 1'b1;
            div_done_ff <= 1'b0;
            div_neg_ff  <= div_neg_in;
            div_cnt_ff  <= 6'(plc_pkg::DIV_W);
            div_rem_ff  <= 48'h0000_0000_0000;
            div_quo_ff  <= div_num_in;
            div_den_ff  <= div_den_in;
        end
        else
        begin
            div_done_ff <= div_busy_ff && (div_cnt_ff == 6'h01);
            if (div_busy_ff)
            begin
                div_rem_ff  <= nxt_rem;
                div_quo_ff  <= {div_quo_ff[46:0], rem_ge};
                div_cnt_ff  <= div_cnt_ff - 6'h01;
                div_busy_ff <= (div_cnt_ff != 6'h01);
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            st_ff         <= plc_pkg::ST_IDLE;
            err_ff        <= '0;
            d_ff          <= '0;
            integ_ff      <= '0;
            filt_ff       <= '0;
            cmd_freq_ff   <= 16'h0000;
            cmd_update_ff <= 1'b0;
        end
        else
        begin
            cmd_update_ff <= 1'b0;
            case (st_ff)
                plc_pkg::ST_IDLE:
                begin
                    if (!cfg_ff.en)
                    begin
                        err_ff   <= '0;
                        d_ff     <= '0;
                        integ_ff <= '0;
                    end
                    else if (run_tick)
                    begin
                        err_ff <= err_w;
                        d_ff   <= d_w;
                        if (cfg_ff.ti == 16'h0000)
                            integ_ff <= '0;
                        st_ff <= int_go ? plc_pkg::ST_INT_DIV : plc_pkg::ST_SUM;
                    end
                end
                plc_pkg::ST_INT_DIV:
                begin
                    if (div_done_ff)
                    begin
                        integ_ff <= plc_sat(integ_ff + qs_w, -ilim_w, ilim_w);
                        st_ff    <= plc_pkg::ST_SUM;
                    end
                end
                plc_pkg::ST_SUM:
                begin
                    if (!flt_go)
                    begin
                        filt_ff <= u_w;
                        st_ff   <= plc_pkg::ST_OUT;
                    end
                    else
                        st_ff <= plc_pkg::ST_FLT_DIV;
                end
                plc_pkg::ST_FLT_DIV:
                begin
                    if (div_done_ff)
                    begin
                        filt_ff <= filt_ff + qs_w;
                        st_ff   <= plc_pkg::ST_OUT;
                    end
                end
                plc_pkg::ST_OUT:
                begin
                    cmd_freq_ff   <= 16'(plc_sat(filt_ff >>> plc_pkg::FRAC, '0, olim_w));
                    cmd_update_ff <= 1'b1;
                    st_ff         <= plc_pkg::ST_IDLE;
                end
                default: st_ff <= plc_pkg::ST_IDLE;
            endcase
        end
    end
    assign prdata     = prdata_ff;
    assign pready     = pready_ff;
    assign pslverr    = pslverr_ff;
    assign cmd_freq   = cmd_freq_ff;
    assign cmd_update = cmd_update_ff;
    sequence s_run_start;
        run_tick ##1 (st_ff != plc_pkg::ST_IDLE);
    endsequence
    property p_update_bound;
        s_run_start |-> ##[1:120] cmd_update_ff;
    endproperty
    a_update_bound: assert property (p_update_bound) else $error("update did not finish");
    property p_out_limit;
        cmd_update_ff |-> plc_pkg::plc_wide_t'(cmd_freq_ff) <= $past(olim_w);
    endproperty
    a_out_limit: assert property (p_out_limit) else $error("command above output limit");
    property p_int_clamp;
        (st_ff == plc_pkg::ST_SUM && $past(st_ff) == plc_pkg::ST_INT_DIV) |->
            (integ_ff <= $past(ilim_w) && integ_ff >= -$past(ilim_w));
    endproperty
    a_int_clamp: assert property (p_int_clamp) else $error("integral outside clamp");
    property p_ti_zero;
        (run_tick && cfg_ff.ti == 16'h0000) |=> (integ_ff == 0) [*2];
    endproperty
    a_ti_zero: assert property (p_ti_zero) else $error("integral alive with zero time");
    // A zero integral time clears the integrator, so hold is only promised while it runs
    property p_int_hold;
        (run_tick && err_w == 0 && cfg_ff.ti != 16'h0000) |=> $stable(integ_ff) ##1 $stable(integ_ff);
    endproperty
    a_int_hold: assert property (p_int_hold) else $error("integral moved on zero error");
    property p_d_zero;
        (run_tick && err_w == err_ff) |=> d_ff == 0;
    endproperty
    a_d_zero: assert property (p_d_zero) else $error("derivative nonzero on steady error");
    property p_err_sign;
        (run_tick && is_pos) |=> err_ff == $past(fb_w) - $past(sp_w);
    endproperty
    a_err_sign: assert property (p_err_sign) else $error("positive feedback error sign wrong");
    property p_err_neg;
        (run_tick && !is_pos && cfg_ff.fbsel != plc_pkg::FB_NONE) |=> err_ff == $past(sp_w) - $past(fb_w);
    endproperty
    a_err_neg: assert property (p_err_neg) else $error("negative feedback error sign wrong");
    property p_p_only;
        (st_ff == plc_pkg::ST_SUM && integ_ff == 0 && d_ff == 0) |-> u_w == plc_sat(p_w, -U_SAT, U_SAT);
    endproperty
    a_p_only: assert property (p_p_only) else $error("output not proportional only");
    property p_no_filter;
        (st_ff == plc_pkg::ST_SUM && cfg_ff.tf == 16'h0000) |=> filt_ff == $past(u_w);
    endproperty
    a_no_filter: assert property (p_no_filter) else $error("unfiltered path not direct");
endmodule

// ---- tb/plc_sensor_model.sv ----
`timescale 1ns/10ps
module plc_sensor_model
#(
    parameter int LAG = 3 // Cycles before a new reading reaches the pins
)
(
    input  wire logic        sys_clk,     // System clock
    input  wire logic [15:0] reading,     // Quantity the sensor measures
    input  wire logic        cmd_update,  // New command strobe
    input  wire logic [15:0] cmd_freq,    // Frequency command
    output logic      [15:0] fb_value_in, // Sensor word
    output logic      [15:0] motor_freq   // Command taken by the motor path
);
    int lag_cnt = 0;
    initial fb_value_in = 16'h0000;
    initial motor_freq = 16'h0000;
    // Whole word moves at once, so the design never sees a torn value
    always @(posedge sys_clk)
    begin
        lag_cnt <= (reading == fb_value_in) ? 0 : lag_cnt + 1;
        if (lag_cnt >= LAG)
            fb_value_in <= reading;
        if (cmd_update)
            motor_freq <= cmd_freq;
    end
endmodule

// ---- tb/plc_pid_loop_controller_test.sv ----
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
$display("ERROR at %0t: got %h expected %h", $time, (g), (e)); end end
module plc_pid_loop_controller_test;
    localparam int TICKS = 200;
    logic        sys_clk = 1'b0;
    logic        nrst = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [15:0] fb_value_in;
    logic [15:0] cmd_freq;
    logic        cmd_update;
    logic [15:0] reading = 16'h0;
    logic [31:0] rdat;
    logic        rerr;
    logic [15:0] cmd;
    logic [15:0] motor_freq;
    int          gap;
    int          bad_count = 0;
    int          total_checks = 0;
    int          cycles = 0;

    always #2 sys_clk = ~sys_clk;

    plc_pid_loop_controller #(.TICK_CYCLES(TICKS)) u_plc_pid_loop_controller
    (
        .sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fb_value_in(fb_value_in), .cmd_freq(cmd_freq), .cmd_update(cmd_update)
    );

    plc_sensor_model #(.LAG(3)) u_plc_sensor_model
    (
        .sys_clk(sys_clk), .reading(reading), .cmd_update(cmd_update),
        .cmd_freq(cmd_freq), .fb_value_in(fb_value_in), .motor_freq(motor_freq)
    );

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do
            @(posedge sys_clk);
        while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_upd(input int n);
        repeat (n)
        begin
            gap = 0;
            do
            begin
                @(posedge sys_clk);
                gap++;
            end
            while (cmd_update !== 1'b1);
        end
        cmd = cmd_freq;
    endtask

    task automatic setup(input logic [31:0] ctrl, kp, ti, td, sp);
        apb(1'b1, plc_pkg::OFF_KP, kp);
        apb(1'b1, plc_pkg::OFF_TI, ti);
        apb(1'b1, plc_pkg::OFF_TD, td);
        apb(1'b1, plc_pkg::OFF_SETP, sp);
        apb(1'b1, plc_pkg::OFF_CTRL, ctrl);
        wait_upd(2);
    endtask

    task automatic rd_integ;
        apb(1'b0, plc_pkg::OFF_INTEG, 32'h0);
    endtask

    task automatic t_regs;
        apb(1'b0, plc_pkg::OFF_KP, 32'h0);
        `CHK(rdat, 32'h0000_000A)
        apb(1'b0, plc_pkg::OFF_TI, 32'h0);
        `CHK(rdat, 32'h0000_0064)
        apb(1'b0, plc_pkg::OFF_ILIM, 32'h0);
        `CHK(rdat, 32'h0000_03E8)
        apb(1'b1, plc_pkg::OFF_CTRL, 32'h0000_0052);
        apb(1'b0, plc_pkg::OFF_CTRL, 32'h0);
        `CHK(rdat, 32'h0000_0052)
        apb(1'b1, plc_pkg::OFF_INTEG, 32'h0000_0055);
        rd_integ;
        `CHK(rdat, 32'h0)
        apb(1'b0, 8'h34, 32'h0);
        `CHK(rerr, 1'b1)
    endtask

    task automatic t_prop;
        setup(32'h0000_0011, 32'h0000_000A, 32'h0, 32'h0, 32'h0000_0064);
        `CHK(cmd, 16'h0064)
        setup(32'h0000_0011, 32'h0000_0005, 32'h0, 32'h0, 32'h0000_0064);
        `CHK(cmd, 16'h0032)
        setup(32'h0000_0011, 32'h0000_1388, 32'h0, 32'h0, 32'h0000_0001);
        `CHK(cmd, 16'h01F4)
    endtask

    // Set point above feedback: only the negative selections may drive a command
    task automatic t_polarity;
        logic [3:0]  sel[7] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h7, 4'h8};
        logic [15:0] exp_cmd;
        reading <= 16'h001E;
        apb(1'b1, plc_pkg::OFF_FBCOM, 32'h0000_001E);
        foreach (sel[i])
        begin
            exp_cmd = (sel[i] inside {4'h1, 4'h2, 4'h7}) ? 16'h0046 : 16'h0;
            setup({24'h0, sel[i], 4'h1}, 32'h0000_000A, 32'h0, 32'h0, 32'h0000_0064);
            `CHK(cmd, exp_cmd)
        end
        reading <= 16'h0;
    endtask

    task automatic t_limit;
        apb(1'b1, plc_pkg::OFF_OLIM, 32'h0000_000A);
        setup(32'h0000_0011, 32'h0000_000A, 32'h0, 32'h0, 32'h0000_03E8);
        `CHK(cmd, 16'h003C)
        apb(1'b1, plc_pkg::OFF_OLIM, 32'h0000_03E8);
    endtask

    task automatic t_integ;
        logic [31:0] first;
        apb(1'b1, plc_pkg::OFF_CTRL, 32'h0);
        apb(1'b1, plc_pkg::OFF_ILIM, 32'h0000_0032);
        setup(32'h0000_0011, 32'h0000_0014, 32'h0000_0001, 32'h0, 32'h0000_0064);
        rd_integ;
        first = rdat;
        wait_upd(1);
        rd_integ;
        `CHK(rdat - first, 32'h0000_000A)
        apb(1'b1, plc_pkg::OFF_ILIM, 32'h0000_0001);
        wait_upd(2);
        rd_integ;
        `CHK(rdat, 32'h0000_0006)
        `CHK(cmd, 16'h00D4)
        apb(1'b1, plc_pkg::OFF_CTRL, 32'h0000_0013);
        wait_upd(2);
        `CHK(cmd, 16'h00CE)
        apb(1'b1, plc_pkg::OFF_SETP, 32'h0);
        wait_upd(2);
        rd_integ;
        `CHK(rdat, 32'h0000_0006)
        apb(1'b1, plc_pkg::OFF_CTRL, 32'h0);
        rd_integ;
        `CHK(rdat, 32'h0)
        apb(1'b1, plc_pkg::OFF_SETP, 32'h0000_0064);
        apb(1'b1, plc_pkg::OFF_CTRL, 32'h0000_0013);
        wait_upd(2);
        apb(1'b1, plc_pkg::OFF_TI, 32'h0);
        wait_upd(2);
        rd_integ;
        `CHK(rdat, 32'h0)
        `CHK(cmd, 16'h00C8)
    endtask

    task automatic t_deriv;
        setup(32'h0000_0011, 32'h0000_000A, 32'h0, 32'h0000_0001, 32'h0000_0064);
        `CHK(cmd, 16'h0064)
        apb(1'b1, plc_pkg::OFF_SETP, 32'h0000_006E);
        wait_upd(1);
        `CHK(cmd, 16'h00D2)
        wait_upd(1);
        `CHK(cmd, 16'h006E)
        `CHK(gap, TICKS)
    endtask

    task automatic t_filter;
        apb(1'b1, plc_pkg::OFF_TD, 32'h0);
        apb(1'b1, plc_pkg::OFF_TF, 32'h0000_0001);
        apb(1'b1, plc_pkg::OFF_SETP, 32'h0000_0456);
        wait_upd(1);
        `CHK(cmd, 16'h0077)
    endtask

    // Mid-run reset must drop the loop history and the command
    task automatic t_reset;
        apb(1'b1, plc_pkg::OFF_TI, 32'h0000_0001);
        wait_upd(2);
        @(posedge sys_clk);
        `CHK(motor_freq, cmd)
        rd_integ;
        `CHK(rdat, 32'h0000_0006)
        nrst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        `CHK(cmd_freq, 16'h0000)
        rd_integ;
        `CHK(rdat, 32'h0)
        apb(1'b0, plc_pkg::OFF_ERR, 32'h0);
        `CHK(rdat, 32'h0)
    endtask

    task automatic wrap_up;
        $display("Checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            bad_count++;
            wrap_up;
        end
    end

    initial
    begin
        repeat (4) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        t_regs;
        t_prop;
        t_polarity;
        t_limit;
        t_integ;
        t_deriv;
        t_filter;
        t_reset;
        wrap_up;
    end
endmodule
